// ==== src/mcsd_consts.svh ====
// Purpose: offsets, field positions, reset values and codes of the status/debug bank
// Assumes: offsets are byte offsets on the serial target port
// Notes:   definitions only
`ifndef MCSD_CONSTS_SVH
`define MCSD_CONSTS_SVH

// register offsets
`define MCSD_OFF_CTRL_FAULT   12'h002
`define MCSD_OFF_DEBUG_TWO    12'h00e
`define MCSD_OFF_ALGORITHM_STATUS  12'h0e4
`define MCSD_OFF_MOTOR_PARAM  12'h0e6
`define MCSD_OFF_MEAS_STATUS  12'h0e8
`define MCSD_OFF_DEBUG_ONE    12'h0ec
`define MCSD_OFF_CUR_GAIN     12'h0f0
`define MCSD_OFF_SPD_GAIN     12'h0f2
`define MCSD_OFF_MONITOR_CTRL 12'h0f4
`define MCSD_OFF_NVM_KEY      12'h0f6
`define MCSD_OFF_NVM_FAULT    12'h24c

// controller fault field positions
`define MCSD_CF_SUMMARY      31
`define MCSD_CF_LOST_C       27
`define MCSD_CF_LOST_B       26
`define MCSD_CF_LOST_A       25
`define MCSD_CF_EMF_MEAS_ERR 24
`define MCSD_CF_ABN_RATE     23
`define MCSD_CF_ABN_EMF      22
`define MCSD_CF_PHASE_LOSS   21
`define MCSD_CF_LOCK_SUM     20
`define MCSD_CF_LOCK_LIMIT   19
`define MCSD_CF_HW_LOCK      18
`define MCSD_CF_SUPPLY_LOW   17
`define MCSD_CF_SUPPLY_HIGH  16
`define MCSD_CF_SPD_SAT      15
`define MCSD_CF_CUR_SAT      14
`define MCSD_CF_MAX_SPD_SAT  13
`define MCSD_CF_PWR_SAT      12
`define MCSD_CF_NVM_WR_LOCK  11
`define MCSD_CF_NVM_RD_LOCK  10
`define MCSD_CF_DRY_RUN      9
`define MCSD_CF_BUS_CRC      6
`define MCSD_CF_NVM_ERR      5
`define MCSD_CF_WATCHDOG     3

// nvm fault field positions
`define MCSD_NF_CRC    4
`define MCSD_NF_PARITY 2

// algorithm status, motor parameter and measurement status fields
`define MCSD_AS_MOD_LSB   16
`define MCSD_AS_DUTY_LSB  4
`define MCSD_AS_READY     2
`define MCSD_MP_EMF_LSB   16
`define MCSD_MS_EMF_DONE  29
`define MCSD_MS_GAIN_DONE 28

// debug one fields
`define MCSD_D1_OVERRIDE   31
`define MCSD_D1_REF_LSB    16
`define MCSD_D1_OPEN_LOOP  15
`define MCSD_D1_ALIGN_HOLD 14
`define MCSD_D1_FORCE_IPD  12
`define MCSD_D1_FORCE_ISD  11

// writable masks and reset values
`define MCSD_D1_WMASK 32'hffffd800
`define MCSD_D2_WMASK 32'h07ffffe7
`define MCSD_D1_RESET 32'h00000000
`define MCSD_D2_RESET 32'h00000000

// reference source and startup codes
`define MCSD_SPEED_MODE_REG    2'h2
`define MCSD_STARTUP_ALIGN     2'h1
`define MCSD_STARTUP_DBL_ALIGN 2'h2

// serial target address, arbitrary value
`define MCSD_TARGET_ADDR 7'h01

`endif

// ==== src/mcsd_pkg.sv ====
// Purpose: types of the status/debug bank
// Assumes: none
// Notes:   core-side status travels as packed structs
`default_nettype none

package mcsd_pkg;

  typedef struct packed {
    logic lost_phase_c_flag;
    logic lost_phase_b_flag;
    logic lost_phase_a_flag;
    logic emf_measure_error;
    logic abnormal_rate_lock;
    logic abnormal_emf_lock;
    logic phase_loss_flag;
    logic lock_limit;
    logic hw_lock_limit;
    logic supply_low_flag;
    logic supply_high_flag;
    logic speed_loop_sat;
    logic current_loop_sat;
    logic max_speed_sat;
    logic bus_power_sat;
    logic nvm_write_lock;
    logic nvm_read_lock;
    logic dry_run;
    logic bus_crc_fault;
    logic nvm_error;
    logic watchdog_fault;
  } mcsd_ctrl_flt_s;

  typedef struct packed {
    logic nvm_crc_error;
    logic nvm_parity_error;
  } mcsd_nvm_flt_s;

  typedef struct packed {
    logic [15:0] applied_mod_index;
    logic [11:0] duty_cmd;
    logic        system_ready_flag;
    logic [7:0]  measured_emf_constant;
    logic        emf_measure_done;
    logic        gain_calc_done;
  } mcsd_algo_s;

  typedef struct packed {
    logic        ref_from_reg;
    logic [14:0] ref_cmd;
    logic        open_loop_force;
    logic        align_hold;
    logic        force_ipd;
    logic        force_isd;
  } mcsd_ctl_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WRITE,
    ST_READ,
    ST_RACK
  } mcsd_state_e;

endpackage : mcsd_pkg

`default_nettype wire

// ==== src/mcsd_regs.sv ====
// Purpose: status and debug register bank behind a serial two-wire target port
// Assumes: scl_i and sda_i are already synchronous to clk_sys_i
// Notes:   frame = addr, offset hi, offset lo, data bytes lsb first; read after offset write
//
// Functional notes
// - fault summary bit 31 is OR of all controller fault flags
// - bits 27..25 name which lost phase caused the no-motor fault
// - abnormal speed bit 23, abnormal emf bit 22, no motor bit 21
// - lock summary bit 20 set when any motor lock triggers
// - supply undervoltage bit 17, overvoltage bit 16
// - saturation flags at bits 15, 14, 13, 12
// - nvm write lock bit 11, read lock bit 10
// - dry run detection at bit 9
// - serial packet crc failure at bit 6
// - emf constant measurement error at bit 24
// - nvm crc error bit 4, parity error bit 2, 32-bit register
// - modulation index in bits 31..16
// - 12-bit duty command in bits 15..4
// - ready flag bit 2 low while defaults copy, high once host may write
// - measured emf constant in bits 23..16, read only
// - emf measurement done at bit 29, low until complete
// - gain calculation done at bit 28
// - override bit 31 takes reference from register regardless of source
// - reference field bits 30..16 used when override or source equals 2
// - bit 15 forces open-loop commutation
// - bit 14 holds align state when startup is single or double align
`timescale 1ns/1ns
`default_nettype none
`include "mcsd_consts.svh"

module mcsd_regs
  import mcsd_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = `MCSD_TARGET_ADDR
)(
  input  wire logic           clk_sys_i,
  input  wire logic           rst_i,
  input  wire logic           scl_i,
  input  wire logic           sda_i,
  output logic                sda_o,
  output logic                sda_oe_o,
  input  wire mcsd_ctrl_flt_s ctrl_flt_i,
  input  wire mcsd_nvm_flt_s  nvm_flt_i,
  input  wire mcsd_algo_s     algo_i,
  input  wire logic [1:0]     speed_mode_i,
  input  wire logic [1:0]     startup_method_i,
  output mcsd_ctl_s           ctl_o,
  output logic [31:0]         debug_two_o
);

  ////////////////////////////////////////////////////////////////////////////
  // status snapshot

  mcsd_ctrl_flt_s ctrl_reg;
  mcsd_nvm_flt_s  nvm_reg;
  mcsd_algo_s     algo_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= '0;
      nvm_reg  <= '0;
      algo_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_flt_i;
      nvm_reg  <= nvm_flt_i;
      algo_reg <= algo_i;
    end
  end

  logic [31:0] flt_word;
  logic [31:0] nvm_word;
  logic [31:0] algo_word;
  logic [31:0] param_word;
  logic [31:0] meas_word;

  // reserved bits stay zero by the defaults
  always_comb
  begin
    flt_word = 32'h0000_0000;
    flt_word[`MCSD_CF_LOST_C]       = ctrl_reg.lost_phase_c_flag;
    flt_word[`MCSD_CF_LOST_B]       = ctrl_reg.lost_phase_b_flag;
    flt_word[`MCSD_CF_LOST_A]       = ctrl_reg.lost_phase_a_flag;
    flt_word[`MCSD_CF_EMF_MEAS_ERR] = ctrl_reg.emf_measure_error;
    flt_word[`MCSD_CF_ABN_RATE]     = ctrl_reg.abnormal_rate_lock;
    flt_word[`MCSD_CF_ABN_EMF]      = ctrl_reg.abnormal_emf_lock;
    flt_word[`MCSD_CF_PHASE_LOSS]   = ctrl_reg.phase_loss_flag;
    flt_word[`MCSD_CF_LOCK_SUM]     = ctrl_reg.abnormal_rate_lock | ctrl_reg.abnormal_emf_lock
                                      | ctrl_reg.phase_loss_flag;
    flt_word[`MCSD_CF_LOCK_LIMIT]   = ctrl_reg.lock_limit;
    flt_word[`MCSD_CF_HW_LOCK]      = ctrl_reg.hw_lock_limit;
    flt_word[`MCSD_CF_SUPPLY_LOW]   = ctrl_reg.supply_low_flag;
    flt_word[`MCSD_CF_SUPPLY_HIGH]  = ctrl_reg.supply_high_flag;
    flt_word[`MCSD_CF_SPD_SAT]      = ctrl_reg.speed_loop_sat;
    flt_word[`MCSD_CF_CUR_SAT]      = ctrl_reg.current_loop_sat;
    flt_word[`MCSD_CF_MAX_SPD_SAT]  = ctrl_reg.max_speed_sat;
    flt_word[`MCSD_CF_PWR_SAT]      = ctrl_reg.bus_power_sat;
    flt_word[`MCSD_CF_NVM_WR_LOCK]  = ctrl_reg.nvm_write_lock;
    flt_word[`MCSD_CF_NVM_RD_LOCK]  = ctrl_reg.nvm_read_lock;
    flt_word[`MCSD_CF_DRY_RUN]      = ctrl_reg.dry_run;
    flt_word[`MCSD_CF_BUS_CRC]      = ctrl_reg.bus_crc_fault;
    flt_word[`MCSD_CF_NVM_ERR]      = ctrl_reg.nvm_error;
    flt_word[`MCSD_CF_WATCHDOG]     = ctrl_reg.watchdog_fault;
    flt_word[`MCSD_CF_SUMMARY]      = |flt_word[30:0];

    nvm_word = 32'h0000_0000;
    nvm_word[`MCSD_NF_CRC]    = nvm_reg.nvm_crc_error;
    nvm_word[`MCSD_NF_PARITY] = nvm_reg.nvm_parity_error;

    algo_word = 32'h0000_0000;
    algo_word[`MCSD_AS_MOD_LSB +: 16] = algo_reg.applied_mod_index;
    algo_word[`MCSD_AS_DUTY_LSB +: 12] = algo_reg.duty_cmd;
    algo_word[`MCSD_AS_READY] = algo_reg.system_ready_flag;

    param_word = 32'h0000_0000;
    param_word[`MCSD_MP_EMF_LSB +: 8] = algo_reg.measured_emf_constant;

    meas_word = 32'h0000_0000;
    meas_word[`MCSD_MS_EMF_DONE]  = algo_reg.emf_measure_done;
    meas_word[`MCSD_MS_GAIN_DONE] = algo_reg.gain_calc_done;
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial target line sensing

  logic scl_reg;
  logic sda_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end
    else
    begin
      scl_reg <= scl_i;
      sda_reg <= sda_i;
    end
  end

  wire scl_rise = scl_i & ~scl_reg;
  wire scl_fall = ~scl_i & scl_reg;
  wire bus_start = scl_i & scl_reg & sda_reg & ~sda_i;
  wire bus_stop  = scl_i & scl_reg & ~sda_reg & sda_i;

  ////////////////////////////////////////////////////////////////////////////
  // frame state machine

  mcsd_state_e state_reg;
  logic [7:0]  rx_reg;
  logic [7:0]  tx_reg;
  logic [2:0]  bit_reg;
  logic [2:0]  byte_reg;
  logic        rw_reg;
  logic        ack_on_reg;
  logic        tx_en_reg;
  logic        to_read_reg;
  logic [11:0] offset_reg;
  logic [23:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic        wr_stb_reg;
  logic [31:0] wr_data_reg;
  logic [31:0] debug_one_reg;
  logic [31:0] debug_two_reg;

  wire [7:0] rx_full  = {rx_reg[6:0], sda_i};
  wire       byte_end = scl_rise & (bit_reg == 3'h7);

  logic [31:0] rd_word;
  // unlisted and left-out offsets read zero
  assign rd_word = (offset_reg == `MCSD_OFF_CTRL_FAULT)   ? flt_word :
                   (offset_reg == `MCSD_OFF_NVM_FAULT)    ? nvm_word :
                   (offset_reg == `MCSD_OFF_ALGORITHM_STATUS)  ? algo_word :
                   (offset_reg == `MCSD_OFF_MOTOR_PARAM)  ? param_word :
                   (offset_reg == `MCSD_OFF_MEAS_STATUS)  ? meas_word :
                   (offset_reg == `MCSD_OFF_DEBUG_ONE)    ? debug_one_reg :
                   (offset_reg == `MCSD_OFF_DEBUG_TWO)    ? debug_two_reg : 32'h0000_0000;

  wire [7:0] rd_byte = (byte_reg < 3'h4) ? rdata_reg[{byte_reg[1:0], 3'h0} +: 8] : 8'h00;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg   <= ST_IDLE;
      rx_reg      <= 8'h00;
      tx_reg      <= 8'hff;
      bit_reg     <= 3'h0;
      byte_reg    <= 3'h0;
      rw_reg      <= 1'b0;
      ack_on_reg  <= 1'b0;
      tx_en_reg   <= 1'b0;
      to_read_reg <= 1'b0;
      offset_reg  <= 12'h000;
      wdata_reg   <= 24'h00_0000;
      rdata_reg   <= 32'h0000_0000;
      wr_stb_reg  <= 1'b0;
      wr_data_reg <= 32'h0000_0000;
    end
    else
    begin
      wr_stb_reg <= 1'b0;
      if (bus_start)
      begin
        state_reg  <= ST_ADDR;
        bit_reg    <= 3'h0;
        ack_on_reg <= 1'b0;
        tx_en_reg  <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg  <= ST_IDLE;
        ack_on_reg <= 1'b0;
        tx_en_reg  <= 1'b0;
      end
      else
      begin
        if (scl_rise)
        begin
          rx_reg  <= rx_full;
          bit_reg <= bit_reg + 3'h1;
        end
        unique case (state_reg)
          ST_IDLE:
          begin
          end
          ST_ADDR:
          begin
            if (byte_end)
            begin
              if (rx_full[7:1] == TARGET_ADDR)
              begin
                rw_reg      <= rx_full[0];
                to_read_reg <= rx_full[0];
                byte_reg    <= 3'h0;
                rdata_reg   <= rd_word;
                state_reg   <= ST_ACK;
              end
              else
              begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              ack_on_reg <= ~ack_on_reg;
              if (ack_on_reg)
              begin
                bit_reg   <= 3'h0;
                state_reg <= to_read_reg ? ST_READ : ST_WRITE;
                tx_reg    <= rd_byte;
                tx_en_reg <= to_read_reg;
              end
            end
          end
          ST_WRITE:
          begin
            if (byte_end)
            begin
              state_reg   <= ST_ACK;
              to_read_reg <= 1'b0;
              if (byte_reg != 3'h7)
              begin
                byte_reg <= byte_reg + 3'h1;
              end
              unique case (byte_reg)
                3'h0: offset_reg[11:8] <= rx_full[3:0];
                3'h1: offset_reg[7:0]  <= rx_full;
                3'h2: wdata_reg[7:0]   <= rx_full;
                3'h3: wdata_reg[15:8]  <= rx_full;
                3'h4: wdata_reg[23:16] <= rx_full;
                3'h5:
                begin
                  wr_stb_reg  <= 1'b1;
                  wr_data_reg <= {rx_full, wdata_reg};
                end
                default:
                begin
                end
              endcase
            end
          end
          ST_READ:
          begin
            // first fall after a controller ack only turns the driver on
            // bit 0 must stand until scl falls, else the release looks like a stop
            if (scl_fall & tx_en_reg)
            begin
              if (bit_reg == 3'h0)
              begin
                state_reg <= ST_RACK;
                byte_reg  <= byte_reg + 3'h1;
              end
              else
              begin
                tx_reg <= {tx_reg[6:0], 1'b1};
              end
            end
          end
          ST_RACK:
          begin
            // controller nack ends the read; ack reloads the next byte
            if (scl_rise)
            begin
              bit_reg   <= 3'h0;
              tx_reg    <= rd_byte;
              tx_en_reg <= 1'b0;
              state_reg <= sda_i ? ST_IDLE : ST_READ;
            end
          end
        endcase
        if ((state_reg == ST_READ) & scl_fall)
        begin
          tx_en_reg <= 1'b1;
        end
      end
    end
  end

  // open drain: only ever pull low, never while scl is high at a new bit
  assign sda_o    = 1'b0;
  assign sda_oe_o = ((state_reg == ST_ACK) & ack_on_reg)
                    | ((state_reg == ST_READ) & tx_en_reg & ~tx_reg[7]);

  ////////////////////////////////////////////////////////////////////////////
  // debug control registers

  // writes land only once defaults are loaded, else the copy would clobber them
  wire wr_ok  = wr_stb_reg & algo_reg.system_ready_flag;
  wire wr_one = wr_ok & (offset_reg == `MCSD_OFF_DEBUG_ONE);
  wire wr_two = wr_ok & (offset_reg == `MCSD_OFF_DEBUG_TWO);

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      debug_one_reg <= `MCSD_D1_RESET;
      debug_two_reg <= `MCSD_D2_RESET;
    end
    else
    begin
      // read-only and reserved bits masked off
      if (wr_one)
      begin
        debug_one_reg <= wr_data_reg & `MCSD_D1_WMASK;
      end
      if (wr_two)
      begin
        debug_two_reg <= wr_data_reg & `MCSD_D2_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // controls to the core

  mcsd_ctl_s ctl_reg;

  wire ref_sel = debug_one_reg[`MCSD_D1_OVERRIDE] | (speed_mode_i == `MCSD_SPEED_MODE_REG);
  // align hold only for align startups
  wire align_start = (startup_method_i == `MCSD_STARTUP_ALIGN)
                     | (startup_method_i == `MCSD_STARTUP_DBL_ALIGN);

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctl_reg <= '0;
    end
    else
    begin
      ctl_reg.ref_from_reg    <= ref_sel;
      ctl_reg.ref_cmd         <= debug_one_reg[`MCSD_D1_REF_LSB +: 15];
      ctl_reg.open_loop_force <= debug_one_reg[`MCSD_D1_OPEN_LOOP];
      ctl_reg.align_hold      <= debug_one_reg[`MCSD_D1_ALIGN_HOLD] & align_start;
      ctl_reg.force_ipd       <= debug_one_reg[`MCSD_D1_FORCE_IPD];
      ctl_reg.force_isd       <= debug_one_reg[`MCSD_D1_FORCE_ISD];
    end
  end

  assign ctl_o       = ctl_reg;
  assign debug_two_o = debug_two_reg;

endmodule : mcsd_regs

`default_nettype wire

// ==== testbench/mcsd_regs_assertions.sv ====
// Purpose: port-level checks of the status/debug bank
// Assumes: one clock domain, async active-high reset
// Notes:   serial-side register contents are judged by the bench
`timescale 1ns/1ns
`default_nettype none

module mcsd_regs_checker
  import mcsd_pkg::*;
(
  input wire logic           clk_sys_i,
  input wire logic           rst_i,
  input wire logic           scl_i,
  input wire logic           sda_i,
  input wire logic           sda_o,
  input wire logic           sda_oe_o,
  input wire mcsd_ctrl_flt_s ctrl_flt_i,
  input wire mcsd_nvm_flt_s  nvm_flt_i,
  input wire mcsd_algo_s     algo_i,
  input wire logic [1:0]     speed_mode_i,
  input wire logic [1:0]     startup_method_i,
  input wire mcsd_ctl_s      ctl_o,
  input wire logic [31:0]    debug_two_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_ref_src;
    speed_mode_i == 2'h2 [*3] |-> ctl_o.ref_from_reg;
  endproperty
  a_ref_src: assert property (p_ref_src) else $error("reference source not from register");
  property p_d2_rsvd;
    (debug_two_o & ~32'h07ffffe7) == 32'h0;
  endproperty
  a_d2_rsvd: assert property (p_d2_rsvd) else $error("reserved debug bit set");
  property p_d2_ready;
    !algo_i.system_ready_flag [*3] |-> $stable(debug_two_o);
  endproperty
  a_d2_ready: assert property (p_d2_ready) else $error("debug two written while not ready");
  // updates only land at a data bit, while the clock line is high
  property p_d2_when;
    $changed(debug_two_o) |-> scl_i;
  endproperty
  a_d2_when: assert property (p_d2_when) else $error("debug two changed outside a write");
  property p_olf_when;
    $changed(ctl_o.open_loop_force) |-> scl_i;
  endproperty
  a_olf_when: assert property (p_olf_when) else $error("open loop changed outside a write");
  property p_olf_ready;
    !algo_i.system_ready_flag [*4] |-> $stable(ctl_o.open_loop_force);
  endproperty
  a_olf_ready: assert property (p_olf_ready) else $error("open loop changed while not ready");
  property p_reset;
    $fell(rst_i) |-> debug_two_o == 32'h0 && !ctl_o.open_loop_force && !sda_oe_o;
  endproperty
  a_reset: assert property (p_reset) else $error("state not cleared by reset");
  property p_align;
    startup_method_i == 2'h0 [*3] |-> !ctl_o.align_hold;
  endproperty
  a_align: assert property (p_align) else $error("align hold without align startup");
  property p_ref_stable;
    !algo_i.system_ready_flag [*4] |-> $stable(ctl_o.ref_cmd);
  endproperty
  a_ref_stable: assert property (p_ref_stable) else $error("reference changed while not ready");
endmodule : mcsd_regs_checker

`default_nettype wire

// ==== testbench/mcsd_host_model.sv ====
// Purpose: serial host that reads and writes the bank
// Assumes: half clock period of 5 system clocks, open-drain data line
// Notes:   words travel lsb byte first, bits msb first
`timescale 1ns/1ns
`default_nettype none
`include "mcsd_consts.svh"

module mcsd_host_model (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_low_o
);
  logic ack_seen;
  logic bit_in;

  initial
  begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
    ack_seen  = 1'b0;
  end

  // long half period so the sampler sees every edge
  task automatic half();
    repeat (5) @(negedge clk_sys_i);
  endtask : half

  task automatic put_bit(input logic b);
    sda_low_o = ~b;
    half();
    scl_o = 1'b1;
    half();
    scl_o = 1'b0;
  endtask : put_bit

  // released line floats high through the pull-up
  task automatic get_bit();
    sda_low_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    bit_in = sda_i;
    scl_o  = 1'b0;
  endtask : get_bit

  task automatic start();
    sda_low_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b0;
  endtask : start

  task automatic stop();
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b0;
    half();
  endtask : stop

  task automatic wr_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit();
    ack_seen = ~bit_in;
  endtask : wr_byte

  task automatic rd_byte(output logic [7:0] b, input logic last);
    for (int i = 7; i >= 0; i--)
    begin
      get_bit();
      b[i] = bit_in;
    end
    put_bit(last);
  endtask : rd_byte

  task automatic head(input logic [11:0] ofs);
    start();
    wr_byte({`MCSD_TARGET_ADDR, 1'b0});
    wr_byte({4'h0, ofs[11:8]});
    wr_byte(ofs[7:0]);
  endtask : head

  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    head(ofs);
    for (int k = 0; k < 4; k++) wr_byte(d[8*k +: 8]);
    stop();
  endtask : wr

  task automatic rd(input logic [11:0] ofs, output logic [31:0] d);
    head(ofs);
    start();
    wr_byte({`MCSD_TARGET_ADDR, 1'b1});
    for (int k = 0; k < 4; k++) rd_byte(d[8*k +: 8], k == 3);
    stop();
  endtask : rd

  task automatic probe(input logic [6:0] addr);
    start();
    wr_byte({addr, 1'b0});
    stop();
  endtask : probe
endmodule : mcsd_host_model

`default_nettype wire

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench of the status/debug bank
// Assumes: host model speaks the two-wire frame of the bank
// Notes:   expected words built from field positions
`timescale 1ns/1ns
`default_nettype none

module testbench
  import mcsd_pkg::*;
;
  logic           clk_sys_i;
  logic           rst_i;
  logic           scl;
  logic           host_low;
  logic           sda_line;
  logic           sda_o;
  logic           sda_oe;
  mcsd_ctrl_flt_s ctrl_flt;
  mcsd_nvm_flt_s  nvm_flt;
  mcsd_algo_s     algo;
  logic [1:0]     speed_mode;
  logic [1:0]     startup;
  mcsd_ctl_s      ctl;
  logic [31:0]    debug_two;
  int             failures;
  int             compares;
  int             pos [21] = '{27, 26, 25, 24, 23, 22, 21, 19, 18, 17, 16, 15, 14, 13, 12, 11, 10, 9, 6, 5, 3};

  assign sda_line = ~(host_low | (sda_oe & ~sda_o));

  mcsd_regs i_mcsd_regs (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .ctrl_flt_i(ctrl_flt), .nvm_flt_i(nvm_flt), .algo_i(algo),
    .speed_mode_i(speed_mode), .startup_method_i(startup), .ctl_o(ctl), .debug_two_o(debug_two)
  );

  mcsd_host_model i_mcsd_host_model (
    .clk_sys_i(clk_sys_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(host_low)
  );

  task automatic close_out();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [11:0] ofs, input logic [31:0] exp);
    logic [31:0] d;
    i_mcsd_host_model.rd(ofs, d);
    chk(d, exp);
  endtask : rd_chk

  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // hang guard
  initial
  begin
    repeat (90000) @(posedge clk_sys_i);
    failures++;
    close_out();
  end

  initial
  begin
    rst_i      = 1'b1;
    ctrl_flt   = '0;
    nvm_flt    = '0;
    algo       = '0;
    speed_mode = 2'h0;
    startup    = 2'h0;
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rd_chk(12'h0ec, 32'h0);
    rd_chk(12'h00e, 32'h0);
    rd_chk(12'h0e4, 32'h0);
    i_mcsd_host_model.wr(12'h0ec, 32'hffffffff);
    rd_chk(12'h0ec, 32'h0);
    i_mcsd_host_model.probe(7'h02);
    chk({31'h0, i_mcsd_host_model.ack_seen}, 32'h0);
    algo = {16'h8001, 12'hfff, 1'b1, 8'ha5, 1'b1, 1'b0};
    rd_chk(12'h0e4, 32'h8001fff4);
    rd_chk(12'h0e6, 32'h00a50000);
    rd_chk(12'h0e8, 32'h20000000);
    algo.emf_measure_done = 1'b0;
    algo.gain_calc_done   = 1'b1;
    rd_chk(12'h0e8, 32'h10000000);
    i_mcsd_host_model.wr(12'h0e4, 32'hffffffff);
    rd_chk(12'h0e4, 32'h8001fff4);
    startup = 2'h1;
    i_mcsd_host_model.wr(12'h0ec, 32'hffffffff);
    rd_chk(12'h0ec, 32'hffffd800);
    chk({12'h0, ctl}, 32'h000fffff);
    startup = 2'h2;
    repeat (3) @(negedge clk_sys_i);
    chk({12'h0, ctl}, 32'h000fffff);
    startup = 2'h0;
    repeat (3) @(negedge clk_sys_i);
    chk({12'h0, ctl}, 32'h000ffffb);
    i_mcsd_host_model.wr(12'h0ec, 32'h12345678);
    rd_chk(12'h0ec, 32'h12345000);
    chk({12'h0, ctl}, 32'h00012342);
    speed_mode = 2'h2;
    startup    = 2'h1;
    repeat (3) @(negedge clk_sys_i);
    chk({12'h0, ctl}, 32'h00092346);
    algo.system_ready_flag = 1'b0;
    i_mcsd_host_model.wr(12'h0ec, 32'h0);
    rd_chk(12'h0ec, 32'h12345000);
    algo.system_ready_flag = 1'b1;
    i_mcsd_host_model.wr(12'h00e, 32'hffffffff);
    rd_chk(12'h00e, 32'h07ffffe7);
    chk(debug_two, 32'h07ffffe7);
    // only reads, never writes, at an unlisted and a left-out place
    rd_chk(12'h100, 32'h0);
    rd_chk(12'h0f0, 32'h0);
    for (int i = 1; i < 4; i++)
    begin
      nvm_flt = i[1:0];
      rd_chk(12'h24c, {27'h0, nvm_flt[1], 1'b0, nvm_flt[0], 2'h0});
    end
    rd_chk(12'h002, 32'h0);
    for (int i = 0; i < 21; i++)
    begin
      ctrl_flt = 21'h1 << (20 - i);
      rd_chk(12'h002, (32'h1 << pos[i]) | 32'h80000000 |
             ((pos[i] inside {[21:23]}) ? 32'h00100000 : 32'h0));
    end
    rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rd_chk(12'h0ec, 32'h0);
    chk(debug_two, 32'h0);
    close_out();
  end
endmodule : testbench

bind mcsd_regs mcsd_regs_checker i_mcsd_regs_checker (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .ctrl_flt_i(ctrl_flt_i), .nvm_flt_i(nvm_flt_i), .algo_i(algo_i),
  .speed_mode_i(speed_mode_i), .startup_method_i(startup_method_i), .ctl_o(ctl_o),
  .debug_two_o(debug_two_o)
);

`default_nettype wire
